// >>> rtl/qdlr_ctrl.sv
// quad converter load strobe, reset and reference control top
// Operation
// RL1 - mask bit 0: channel output follows the hardware load strobe normally
// RL2 - mask bit 1: channel sees load strobe high, pin ignored
// RL3 - load strobe falling edge copies input to output for unmasked channels
// RL4 - load strobe held low makes mask bits irrelevant
// RL5 - hardware reset clears outputs to zero or midscale per select pin
// RL6 - after hardware reset outputs hold cleared code until new write
// RL7 - no output loads while hardware reset is low
// RL8 - command 0110 returns converter to power-on reset code
// RL9 - load strobe and hardware reset ignored during power-on reset
// RL10 - power-up to zero scale if select low, midscale if high
// RL11 - outputs stay at power-on level until a valid write
// RL12 - internal reference enabled at power-up
// RL13 - command 0111 bit 0: 0 keeps reference on, 1 turns it off
// RL14 - reference command ignores address and bits 19 to 1
// RL15 - host sends 24-bit words, acted on at frame sync rise
// RL16 - host drives clock, data and frame sync, three or four wire
// RL17 - command 0101 loads four mask bits from bits 3 to 0
// RL18 - strobe low during input write updates input and output together
// RL19 - frames of exactly 24 clocks, msb first; others ignored
module qdlr_ctrl
  import qdlr_pkg::*;
#(
  parameter int unsigned CHANNELS = qdlr_pkg::QDLR_CHANNELS,
  parameter int unsigned POR_CYC = qdlr_pkg::QDLR_POR_CYC
)
(
  // system
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // serial link
  input wire logic SCLK_IN,
  input wire logic SYNC_N_IN,
  input wire logic SDIN_IN,
  // control pins
  input wire logic LOAD_STROBE_N_IN,
  input wire logic HW_RESET_N_IN,
  input wire logic RESET_LEVEL_SELECT_IN,
  // converter codes and state
  output logic [qdlr_pkg::QDLR_CODE_W*qdlr_pkg::QDLR_CHANNELS-1:0] ANALOG_OUTPUT_CODE_OUT,
  output logic [qdlr_pkg::QDLR_CHANNELS-1:0] LOAD_MASK_OUT,
  output logic REF_ENABLE_OUT,
  output logic POR_BUSY_OUT
);
  import qdlr_pkg::*;

  initial
  begin
    if (CHANNELS != QDLR_CHANNELS || POR_CYC == 0 || POR_CYC >= (1 << QDLR_POR_W))
      $error("qdlr_ctrl: unsupported parameter values");
  end

  // link receiver on its own clock
  logic [QDLR_WORD_W-1:0] rx_word;
  logic rx_toggle;
  qdlr_link_rx u_rx (
    .SCLK_IN(SCLK_IN),
    .SYNC_N_IN(SYNC_N_IN),
    .SDIN_IN(SDIN_IN),
    .NRST_IN(NRST_IN),
    .word_out(rx_word),
    .toggle_out(rx_toggle)
  );

  // two-flop synchronisers; first stage read only by second
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic tog_s3_q;
  logic strobe_d1_q;
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      // toggle starts at the receiver's reset level so no false word follows reset
      s1_q <= 4'h6;
      s2_q <= 4'h6;
    end
    else
    begin
      s1_q <= {rx_toggle, LOAD_STROBE_N_IN, HW_RESET_N_IN, RESET_LEVEL_SELECT_IN};
      s2_q <= s1_q;
    end
  end
  wire tog_s = s2_q[3];
  wire strobe_n_s = s2_q[2];
  wire hw_rst_n_s = s2_q[1];
  wire level_sel_s = s2_q[0];

  // word captured only after the toggle has settled, so the bus is stable
  logic [QDLR_WORD_W-1:0] word_q;
  logic word_vld_q;
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      tog_s3_q <= 1'b0;
      word_q <= '0;
      word_vld_q <= 1'b0;
    end
    else
    begin
      tog_s3_q <= tog_s;
      word_vld_q <= tog_s ^ tog_s3_q;
      if (tog_s ^ tog_s3_q)
        word_q <= rx_word; // see RL15
    end
  end

  // power-on counter
  logic [QDLR_POR_W-1:0] por_cnt_q;
  wire por_busy = por_cnt_q != '0;
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      por_cnt_q <= QDLR_POR_W'(POR_CYC);
    else if (por_busy)
      por_cnt_q <= por_cnt_q - QDLR_POR_W'(1);
  end

  // decode of the received word
  wire [3:0] cmd = word_q[QDLR_CMD_MSB:QDLR_CMD_LSB];
  wire [3:0] addr = word_q[QDLR_ADDR_MSB:QDLR_ADDR_LSB];
  wire [QDLR_CODE_W-1:0] data = word_q[QDLR_CODE_W-1:0];
  wire cmd_ok = word_vld_q && !por_busy;
  wire do_wr_in = cmd_ok && cmd == QDLR_CMD_WR_INPUT;
  wire do_upd = cmd_ok && cmd == QDLR_CMD_UPD_OUT;
  wire do_wr_upd = cmd_ok && cmd == QDLR_CMD_WR_UPD;
  wire do_mask = cmd_ok && cmd == QDLR_CMD_MASK; // address ignored, see RL17
  wire do_soft = cmd_ok && cmd == QDLR_CMD_SOFT_RST; // see RL8
  wire do_ref = cmd_ok && cmd == QDLR_CMD_REF; // only bit 0 matters, see RL14

  // pins ignored while power-on reset runs
  wire hw_rst_act = hw_rst_n_s == 1'b0 && !por_busy; // see RL9
  wire strobe_fall = strobe_d1_q && !strobe_n_s && !por_busy; // see RL3 see RL9
  wire strobe_low = !strobe_n_s && !por_busy;

  // clear code chosen by the level select pin
  function automatic logic [QDLR_CODE_W-1:0] clear_code(input logic sel);
    clear_code = sel ? QDLR_MID_CODE : QDLR_ZERO_CODE;
  endfunction : clear_code

  // per-channel registers
  logic [QDLR_CODE_W-1:0] in_q [QDLR_CHANNELS];
  logic [QDLR_CODE_W-1:0] out_q [QDLR_CHANNELS];
  logic [QDLR_CHANNELS-1:0] mask_q;
  logic ref_off_q;
  logic por_d1_q;
  logic [QDLR_CHANNELS-1:0] load_ch;
  logic [QDLR_CHANNELS-1:0] wr_ch;

  // load decision per channel
  always_comb
  begin
    for (int i = 0; i < QDLR_CHANNELS; i++)
    begin
      wr_ch[i] = addr[i] && (do_wr_in || do_wr_upd);
      // edge loads unmasked channels; mask forces strobe high, see RL1 see RL2
      load_ch[i] = (strobe_fall && !mask_q[i])
        || (addr[i] && (do_upd || do_wr_upd))
        || (do_wr_in && addr[i] && strobe_low); // mask not consulted, see RL4 see RL18
    end
  end

  // strobe edge tracker
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      strobe_d1_q <= 1'b1;
    else
      strobe_d1_q <= strobe_n_s;
  end

  // input and output codes; reset blocks loads, see RL5 see RL7
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      for (int i = 0; i < QDLR_CHANNELS; i++)
      begin
        in_q[i] <= QDLR_ZERO_CODE;
        out_q[i] <= QDLR_ZERO_CODE;
      end
    end
    else
    begin
      for (int i = 0; i < QDLR_CHANNELS; i++)
      begin
        if (por_busy || hw_rst_act || do_soft) // see RL10 see RL5 see RL8
        begin
          in_q[i] <= clear_code(level_sel_s);
          out_q[i] <= clear_code(level_sel_s);
        end
        else
        begin
          // outputs otherwise hold their level, see RL6 see RL11
          if (wr_ch[i])
            in_q[i] <= data;
          if (load_ch[i])
            out_q[i] <= wr_ch[i] ? data : in_q[i];
        end
      end
    end
  end

  // mask and reference control
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      mask_q <= QDLR_MASK_RST;
      ref_off_q <= QDLR_REF_OFF_RST; // see RL12
    end
    else if (do_soft)
    begin
      mask_q <= QDLR_MASK_RST;
      ref_off_q <= QDLR_REF_OFF_RST;
    end
    else
    begin
      if (do_mask)
        mask_q <= word_q[QDLR_CHANNELS-1:0]; // see RL17
      if (do_ref)
        ref_off_q <= word_q[QDLR_REF_BIT]; // see RL13
    end
  end

  // registered outputs
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      ANALOG_OUTPUT_CODE_OUT <= '0;
      LOAD_MASK_OUT <= '0;
      REF_ENABLE_OUT <= 1'b1;
      POR_BUSY_OUT <= 1'b1;
      por_d1_q <= 1'b1;
    end
    else
    begin
      for (int i = 0; i < QDLR_CHANNELS; i++)
        ANALOG_OUTPUT_CODE_OUT[i*QDLR_CODE_W +: QDLR_CODE_W] <= out_q[i];
      LOAD_MASK_OUT <= mask_q;
      REF_ENABLE_OUT <= !ref_off_q;
      POR_BUSY_OUT <= por_busy;
      por_d1_q <= por_busy;
    end
  end

  // checks: strobe edges against the mask
  a_mask_blocks_load: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL2
    (strobe_fall && mask_q[0] && !word_vld_q && !hw_rst_act)
    |=> $stable(out_q[0]))
    else $error("masked channel loaded on strobe edge");
  a_mask_blocks_ch2: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL2
    (strobe_fall && mask_q[2] && !word_vld_q && !hw_rst_act)
    |=> $stable(out_q[2]))
    else $error("masked channel two loaded on strobe edge");
  a_edge_loads_ch: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL3
    (strobe_fall && !mask_q[1] && !hw_rst_act && !word_vld_q)
    |=> out_q[1] == $past(in_q[1]))
    else $error("unmasked channel missed strobe edge");
  a_edge_loads_ch3: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL3
    (strobe_fall && !mask_q[3] && !hw_rst_act && !word_vld_q)
    |=> out_q[3] == $past(in_q[3]))
    else $error("unmasked channel three missed strobe edge");

  // checks: hardware reset pin
  a_reset_clears: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL5
    hw_rst_act
    |=> out_q[2] == clear_code($past(level_sel_s)))
    else $error("hardware reset did not clear output");
  a_reset_out_pin: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL5
    hw_rst_act
    |=> ##1 ANALOG_OUTPUT_CODE_OUT[QDLR_CODE_W-1:0] == clear_code($past(level_sel_s, 2)))
    else $error("hardware reset did not reach output port");
  a_reset_blocks: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL7
    (hw_rst_act && do_wr_upd)
    |=> out_q[0] == clear_code($past(level_sel_s)) && in_q[0] == clear_code($past(level_sel_s)))
    else $error("output loaded during hardware reset");
  a_reset_holds_in: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL7
    hw_rst_act
    |=> in_q[1] == clear_code($past(level_sel_s)))
    else $error("input register written during hardware reset");
  // with no strobe edge, word or reset the outputs must not drift
  a_hold_idle: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL6
    (!strobe_fall && !word_vld_q && !hw_rst_act && !por_busy)
    |=> $stable(out_q[0]) && $stable(out_q[3]))
    else $error("output changed without a load event");
  a_hold_idle_mid: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL11
    (!strobe_fall && !word_vld_q && !hw_rst_act && !por_busy)
    |=> $stable(out_q[1]) && $stable(out_q[2]))
    else $error("middle output changed without a load event");

  // checks: software reset
  a_soft_reset: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL8
    do_soft
    |=> mask_q == QDLR_MASK_RST && !ref_off_q && out_q[3] == clear_code($past(level_sel_s)))
    else $error("software reset incomplete");
  a_soft_in_clear: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL8
    do_soft
    |=> in_q[0] == clear_code($past(level_sel_s)))
    else $error("software reset left input register");

  // checks: power-on window
  a_por_ignores: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL9
    por_busy
    |=> out_q[1] == clear_code($past(level_sel_s)))
    else $error("output moved during power-on reset");
  a_por_counts: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL10
    por_busy
    |=> por_cnt_q == $past(por_cnt_q) - QDLR_POR_W'(1))
    else $error("power-on window not counting down");
  a_por_defaults: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL12
    por_busy
    |-> !ref_off_q && mask_q == QDLR_MASK_RST)
    else $error("reference or mask not at power-up default");
  a_por_release: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL10
    (por_d1_q && !por_busy)
    |-> out_q[0] == clear_code($past(level_sel_s)) && !ref_off_q)
    else $error("power-up level or reference wrong at release");

  // checks: reference and mask commands
  a_ref_cmd: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL13
    do_ref
    |=> ##1 REF_ENABLE_OUT == !$past(word_q[QDLR_REF_BIT], 2))
    else $error("reference command not applied");
  a_ref_holds: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL13
    (!do_ref && !do_soft)
    |=> ref_off_q == $past(ref_off_q))
    else $error("reference changed without a command");
  a_mask_cmd: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL17
    (do_mask && !do_soft)
    |=> mask_q == $past(word_q[3:0]))
    else $error("mask command not applied");

  // checks: direct write with the strobe held low
  a_low_strobe_write: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL18
    (do_wr_in && addr[2] && strobe_low && !hw_rst_act)
    |=> out_q[2] == $past(data) && in_q[2] == $past(data))
    else $error("write with strobe low did not reach output");
  a_low_strobe_masked: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // see RL4
    (do_wr_in && addr[2] && mask_q[2] && strobe_low && !hw_rst_act)
    |=> out_q[2] == $past(data))
    else $error("mask blocked a write with strobe held low");
endmodule : qdlr_ctrl

// >>> rtl/qdlr_pkg.sv
// shared constants for the quad converter load, reset and reference control
package qdlr_pkg;
  localparam int unsigned QDLR_CHANNELS = 4;
  localparam int unsigned QDLR_CODE_W = 16;
  localparam int unsigned QDLR_WORD_W = 24;
  localparam int unsigned QDLR_CNT_W = 5;
  // command field position
  localparam int unsigned QDLR_CMD_MSB = 23;
  localparam int unsigned QDLR_CMD_LSB = 20;
  localparam int unsigned QDLR_ADDR_MSB = 19;
  localparam int unsigned QDLR_ADDR_LSB = 16;
  localparam int unsigned QDLR_REF_BIT = 0;
  // command codes
  localparam logic [3:0] QDLR_CMD_WR_INPUT = 4'h1;
  localparam logic [3:0] QDLR_CMD_UPD_OUT = 4'h2;
  localparam logic [3:0] QDLR_CMD_WR_UPD = 4'h3;
  localparam logic [3:0] QDLR_CMD_MASK = 4'h5;
  localparam logic [3:0] QDLR_CMD_SOFT_RST = 4'h6;
  localparam logic [3:0] QDLR_CMD_REF = 4'h7;
  // reset values
  localparam logic [3:0] QDLR_MASK_RST = 4'h0;
  localparam logic QDLR_REF_OFF_RST = 1'b0;
  localparam logic [15:0] QDLR_ZERO_CODE = 16'h0000;
  localparam logic [15:0] QDLR_MID_CODE = 16'h8000;
  // power-on hold time and its cycle count at 40 MHz
  localparam int unsigned QDLR_CLK_MHZ = 40;
  localparam int unsigned QDLR_POR_NS = 1000;
  localparam int unsigned QDLR_POR_CYC = (QDLR_POR_NS * QDLR_CLK_MHZ + 999) / 1000;
  localparam int unsigned QDLR_POR_W = 6;
endpackage : qdlr_pkg

// >>> rtl/qdlr_link_rx.sv
// serial link receiver on the link clock, hands complete words over by toggle
module qdlr_link_rx
  import qdlr_pkg::*;
(
  // link side
  input wire logic SCLK_IN,
  input wire logic SYNC_N_IN,
  input wire logic SDIN_IN,
  input wire logic NRST_IN,
  // word handover
  output logic [qdlr_pkg::QDLR_WORD_W-1:0] word_out,
  output logic toggle_out
);
  logic [QDLR_WORD_W-1:0] shift_q;
  logic [QDLR_CNT_W-1:0] cnt_q;
  logic sync_n_d1_q;
  wire frame_end = SYNC_N_IN && !sync_n_d1_q;

  // shift on falling edge while framed; link clock may stop after the first falling edge that follows frame sync rise
  always_ff @(negedge SCLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      shift_q <= '0;
      cnt_q <= '0;
      sync_n_d1_q <= 1'b1;
      word_out <= '0;
      toggle_out <= 1'b0;
    end
    else
    begin
      sync_n_d1_q <= SYNC_N_IN;
      if (!SYNC_N_IN)
      begin
        shift_q <= {shift_q[QDLR_WORD_W-2:0], SDIN_IN}; // msb first, see RL19
        if (sync_n_d1_q)
          cnt_q <= QDLR_CNT_W'(1);
        else if (cnt_q != '1) // saturates so overlong frames stay refused
          cnt_q <= cnt_q + QDLR_CNT_W'(1);
      end
      // only exactly 24 bits hand over, see RL15 see RL19
      if (frame_end && cnt_q == QDLR_CNT_W'(QDLR_WORD_W))
      begin
        word_out <= shift_q;
        toggle_out <= !toggle_out;
      end
    end
  end

  // a handover only ever follows a frame of exactly one word
  a_frame_length: assert property (@(negedge SCLK_IN) disable iff (!NRST_IN) // see RL19
    (toggle_out != $past(toggle_out))
    |-> $past(cnt_q) == QDLR_CNT_W'(QDLR_WORD_W))
    else $error("word handed over after a frame of wrong length");
endmodule : qdlr_link_rx

// >>> testbench/qdlr_host_model.sv
// host serial master model that frames words onto the link
module qdlr_host_model
(
  // link outputs
  output logic sclk_out,
  output logic sync_n_out,
  output logic sdin_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // link idle: clock parked high, frame sync high
  initial
  begin
    sclk_out = 1'b1;
    sync_n_out = 1'b1;
    sdin_out = 1'b0;
  end

  // three-wire frame with the clock running inside it plus one pulse after frame sync rises
  // command in the top nibble comes first
  // nbits other than 24 is only used to build frames that must be refused
  task automatic send(input logic [23:0] word, input int nbits);
    sync_n_out = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      sdin_out = word[23 - (i % 24)]; // msb first
      #32 sclk_out = 1'b0;
      #32 sclk_out = 1'b1;
    end
    sdin_out = ~sdin_out; // released line must not show a stale bit
    sync_n_out = 1'b1; // word ends on frame sync rise
    #32 sclk_out = 1'b0; // extra edge lets the receiver hand the word over
    #32 sclk_out = 1'b1;
  endtask : send
endmodule : qdlr_host_model

// >>> testbench/testbench.sv
// self-checking bench for the quad converter control block
module testbench;
  import qdlr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned POR_T = 8;
  typedef struct packed {logic [23:0] word; logic [63:0] codes; logic [3:0] mask; logic ref_on;}
    qdlr_row_t;
  // ordinary commands with the state expected after each
  localparam qdlr_row_t ROWS [9] = '{
    '{24'h311234, 64'h0000_0000_0000_1234, 4'h0, 1'b1},
    '{24'h12ABCD, 64'h0000_0000_0000_1234, 4'h0, 1'b1},
    '{24'h220000, 64'h0000_0000_ABCD_1234, 4'h0, 1'b1},
    '{24'h5F0005, 64'h0000_0000_ABCD_1234, 4'h5, 1'b1},
    '{24'h7FFFFE, 64'h0000_0000_ABCD_1234, 4'h5, 1'b1},
    '{24'h700001, 64'h0000_0000_ABCD_1234, 4'h5, 1'b0},
    '{24'h185555, 64'h0000_0000_ABCD_1234, 4'h5, 1'b0},
    '{24'h146666, 64'h0000_0000_ABCD_1234, 4'h5, 1'b0},
    '{24'h117777, 64'h0000_0000_ABCD_1234, 4'h5, 1'b0}};
  logic clk;
  logic nrst;
  logic ld_n;
  logic hw_n;
  logic sel;
  wire logic sclk;
  wire logic sync_n;
  wire logic sdin;
  wire logic [63:0] codes;
  wire logic [3:0] mask;
  wire logic ref_en;
  wire logic por;
  int mismatches;
  int tests_run;

  qdlr_ctrl #(.POR_CYC(POR_T)) u_qdlr_ctrl (.CLK_IN(clk), .NRST_IN(nrst), .SCLK_IN(sclk),
    .SYNC_N_IN(sync_n), .SDIN_IN(sdin), .LOAD_STROBE_N_IN(ld_n), .HW_RESET_N_IN(hw_n),
    .RESET_LEVEL_SELECT_IN(sel), .ANALOG_OUTPUT_CODE_OUT(codes), .LOAD_MASK_OUT(mask),
    .REF_ENABLE_OUT(ref_en), .POR_BUSY_OUT(por));
  qdlr_host_model u_host (.sclk_out(sclk), .sync_n_out(sync_n), .sdin_out(sdin));

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles

  // compares codes, mask and reference off the edge, then realigns to the next edge
  task automatic state(input logic [63:0] c, input logic [3:0] m, input logic r);
    #1;
    check("codes", codes, c);
    check("mask", {60'h0, mask}, {60'h0, m});
    check("ref", {63'h0, ref_en}, {63'h0, r});
    @(posedge clk);
  endtask : state

  // codes compared off the edge, then realigned so drives stay on the edge
  task automatic probe(input logic [63:0] c);
    #1;
    check("codes", codes, c);
    @(posedge clk);
  endtask : probe

  // frame then allow the sync, decode and output register stages to settle
  task automatic frame(input logic [23:0] w, input int n);
    u_host.send(w, n);
    cycles(10);
  endtask : frame

  // reset with the select level given; the power-on window must close in time
  task automatic do_reset(input logic s);
    int n;
    sel <= s;
    nrst <= 1'b0;
    cycles(6);
    nrst <= 1'b1;
    cycles(1);
    #1;
    check("por_busy", {63'h0, por}, 64'h1);
    n = 0;
    while (por !== 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 100)
    begin
      mismatches++;
      print_verdict();
    end
    @(posedge clk);
  endtask : do_reset

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    ld_n = 1'b1;
    hw_n = 1'b1;
    sel = 1'b0;
    mismatches = 0;
    tests_run = 0;
    do_reset(1'b0);
    state(64'h0, 4'h0, 1'b1);
    cycles(20);
    state(64'h0, 4'h0, 1'b1);
    foreach (ROWS[i])
    begin
      frame(ROWS[i].word, 24);
      state(ROWS[i].codes, ROWS[i].mask, ROWS[i].ref_on);
    end
    // strobe pulse: channels 0 and 2 are masked and must not move
    ld_n <= 1'b0;
    cycles(2);
    ld_n <= 1'b1;
    cycles(10);
    state(64'h5555_0000_ABCD_1234, 4'h5, 1'b0);
    // strobe held low overrides the mask for a direct write
    ld_n <= 1'b0;
    cycles(10);
    frame(24'h141111, 24);
    state(64'h5555_1111_ABCD_1234, 4'h5, 1'b0);
    ld_n <= 1'b1;
    // short and long frames are dropped
    frame(24'h31FFFF, 23);
    frame(24'h31FFFF, 25);
    state(64'h5555_1111_ABCD_1234, 4'h5, 1'b0);
    // hardware reset to midscale, writes blocked while it is low
    sel <= 1'b1;
    hw_n <= 1'b0;
    cycles(10);
    probe(64'h8000_8000_8000_8000);
    frame(24'h3F4321, 24);
    probe(64'h8000_8000_8000_8000);
    hw_n <= 1'b1;
    cycles(10);
    probe(64'h8000_8000_8000_8000);
    frame(24'h384321, 24);
    probe(64'h4321_8000_8000_8000);
    // software reset returns codes, mask and reference to power-on state
    sel <= 1'b0;
    frame(24'h600000, 24);
    state(64'h0, 4'h0, 1'b1);
    do_reset(1'b1);
    state(64'h8000_8000_8000_8000, 4'h0, 1'b1);
    print_verdict();
  end
endmodule : testbench
